/* rtl/sample_map_params.svh */
// constants of the transport-layer sample mapper
`ifndef SAMPLE_MAP_PARAMS_SVH
`define SAMPLE_MAP_PARAMS_SVH

`define SAMPLE_W 9
`define LANE_N 8
`define OCTET_MAX 5
`define LANE_BITS 40

// link format select codes
`define FMT_1 4'h1
`define FMT_2 4'h2
`define FMT_3 4'h3
`define FMT_4 4'h4
`define FMT_5 4'h5
`define FMT_6 4'h6
`define FMT_7 4'h7
`define FMT_8 4'h8
`define FMT_9 4'h9

// lane counts per format, nibbles {quad, dual, single}
`define LANES_F1 12'h632
`define LANES_F2 12'h421
`define LANES_F3 12'h421
`define LANES_F4 12'h321
`define LANES_F5 12'h211
`define LANES_F6 12'h632
`define LANES_F7 12'h421
`define LANES_F8 12'h421
`define LANES_F9 12'h842

// octets per lane frame
`define OCT_F1 3'h2
`define OCT_F2 3'h1
`define OCT_F3 3'h5
`define OCT_F4 3'h2
`define OCT_F5 3'h2
`define OCT_F6 3'h2
`define OCT_F7 3'h1
`define OCT_F8 3'h3
`define OCT_F9 3'h1

// channel mode codes
`define MODE_QUAD 2'h0
`define MODE_DUAL 2'h1
`define MODE_SINGLE 2'h2

`endif

/* rtl/sample_map_pkg.sv */
// types shared by both ends of the sample mapper
package sample_map_pkg;
    typedef logic [8:0] sample_t;
    typedef sample_t [3:0] chan_t;
    typedef chan_t [3:0] samples_t;
    typedef logic [7:0][39:0] lanes_t;
    typedef enum logic [1:0]
    {
        mode_quad = 2'b00,
        mode_dual = 2'b01,
        mode_single = 2'b10
    } mode_t;
endpackage : sample_map_pkg

/* rtl/lane_link_if.sv */
// frame link between the mapper and the receiver
`timescale 1ns/10ps
interface lane_link_if;
    import sample_map_pkg::*;
    logic frame_valid;
    logic frame_ready;
    lanes_t lane_data;
    logic [7:0] lane_active;
    logic [2:0] octet_count;

    modport tx
    (
        output frame_valid,
        input frame_ready,
        output lane_data,
        output lane_active,
        output octet_count
    );
    modport rx
    (
        input frame_valid,
        output frame_ready,
        input lane_data,
        input lane_active,
        input octet_count
    );
endinterface : lane_link_if

/* rtl/sample_mapper_tx.sv */
// device end: packs channel samples into lane frames
`timescale 1ns/10ps
`include "sample_map_params.svh"
module sample_mapper_tx
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // configuration
    input wire logic [3:0] link_format_select_i,
    input wire sample_map_pkg::mode_t mode_i,
    // sample source
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire sample_map_pkg::samples_t samples_i,
    // link
    lane_link_if.tx link
);
    import sample_map_pkg::*;

    localparam int ENTRY_W = 320 + 8 + 3;

    // lane triple: three 16-bit frames, zb/zc blank the shared bits
    function automatic logic [47:0] pack3(input sample_t a,
        input sample_t b, input sample_t c, input sample_t d,
        input logic zb, input logic zc);
        logic [15:0] l0;
        logic [15:0] l1;
        logic [15:0] l2;
        l0 = {a, 3'h0, (zb ? 4'h0 : b[8:5])};
        l1 = {b[4:0], 3'h0, (zc ? 8'h00 : c[8:1])};
        l2 = {c[0], 3'h0, d, 3'h0};
        return {l0, l1, l2};
    endfunction : pack3

    function automatic logic [3:0] pick(input logic [11:0] tbl,
        input mode_t m);
        logic [3:0] n;
        unique case (m)
            mode_quad: n = tbl[11:8];
            mode_dual: n = tbl[7:4];
            mode_single: n = tbl[3:0];
            default: n = 4'h0;
        endcase
        return n;
    endfunction : pick

    lanes_t frame;
    logic [47:0] tri_lo;
    logic [47:0] tri_hi;
    logic [3:0] lane_cnt;
    logic [2:0] octets;
    logic [7:0] active;
    logic single;
    logic dual;

    assign single = (mode_i == mode_single);
    assign dual = (mode_i == mode_dual);

    // packing depends on the format code only; mode blanks shared bits and sets the lane count
    always_comb
    begin
        frame = '0;
        tri_lo = '0;
        tri_hi = '0;
        lane_cnt = 4'h0;
        octets = 3'h0;
        unique case (link_format_select_i)
            `FMT_1, `FMT_6:
            begin
                tri_lo = pack3(samples_i[0][0], samples_i[0][1],
                    samples_i[1][0], samples_i[1][1], 1'b0,
                    single);
                tri_hi = pack3(samples_i[2][0], samples_i[2][1],
                    samples_i[3][0], samples_i[3][1], 1'b0,
                    1'b0);
                frame[0] = {tri_lo[47:32], 24'h0};
                frame[1] = {tri_lo[31:16], 24'h0};
                frame[2] = {tri_lo[15:0], 24'h0};
                frame[3] = {tri_hi[47:32], 24'h0};
                frame[4] = {tri_hi[31:16], 24'h0};
                frame[5] = {tri_hi[15:0], 24'h0};
                if (link_format_select_i == `FMT_1)
                begin
                    lane_cnt = pick(`LANES_F1, mode_i);
                    octets = `OCT_F1;
                end
                else
                begin
                    lane_cnt = pick(`LANES_F6, mode_i);
                    octets = `OCT_F6;
                end
            end
            `FMT_2, `FMT_7:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    frame[c] = {samples_i[c][0][8:1], 32'h0};
                end
                if (link_format_select_i == `FMT_2)
                begin
                    lane_cnt = pick(`LANES_F2, mode_i);
                    octets = `OCT_F2;
                end
                else
                begin
                    lane_cnt = pick(`LANES_F7, mode_i);
                    octets = `OCT_F7;
                end
            end
            `FMT_3:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    frame[c] = {samples_i[c][0], 1'b0,
                        samples_i[c][1], 1'b0, samples_i[c][2], 1'b0,
                        samples_i[c][3], 1'b0};
                end
                lane_cnt = pick(`LANES_F3, mode_i);
                octets = `OCT_F3;
            end
            `FMT_4:
            begin
                tri_lo = pack3(samples_i[0][0], samples_i[1][0],
                    samples_i[2][0], samples_i[3][0], single,
                    dual);
                frame[0] = {tri_lo[47:32], 24'h0};
                frame[1] = {tri_lo[31:16], 24'h0};
                frame[2] = {tri_lo[15:0], 24'h0};
                lane_cnt = pick(`LANES_F4, mode_i);
                octets = `OCT_F4;
            end
            `FMT_5:
            begin
                frame[0] = {samples_i[0][0][8:1],
                    (single ? 8'h00 : samples_i[1][0][8:1]),
                    24'h0};
                frame[1] = {samples_i[2][0][8:1],
                    samples_i[3][0][8:1], 24'h0};
                lane_cnt = pick(`LANES_F5, mode_i);
                octets = `OCT_F5;
            end
            `FMT_8:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    frame[c] = {samples_i[c][0], 3'h0, samples_i[c][1],
                        3'h0, 16'h0};
                end
                lane_cnt = pick(`LANES_F8, mode_i);
                octets = `OCT_F8;
            end
            `FMT_9:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    frame[2 * c] = {samples_i[c][0][8:1], 32'h0};
                    frame[2 * c + 1] = {samples_i[c][1][8:1], 32'h0};
                end
                lane_cnt = pick(`LANES_F9, mode_i);
                octets = `OCT_F9;
            end
            default:
            begin
                // unsupported code: no lane carries data
                lane_cnt = 4'h0;
                octets = 3'h0;
            end
        endcase
        // constant zero fills above act as tail and pad bits
        for (int l = 0; l < 8; l++)
        begin
            active[l] = (4'(l) < lane_cnt);
            if (!active[l])
            begin
                frame[l] = '0;
            end
        end
    end

    // two-entry buffer, head register drives the link directly
    logic [ENTRY_W-1:0] head_reg;
    logic [ENTRY_W-1:0] tail_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic valid_reg;
    logic room_reg;
    logic push;
    logic pop;
    logic [ENTRY_W-1:0] entry_in;

    // samples are 9 bits MSB first; 8-bit formats drop bit 0
    assign entry_in = {frame, active, octets};
    assign push = sample_valid_i & room_reg;
    assign pop = valid_reg & link.frame_ready;

    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
        begin
            count_next = count_reg + 2'h1;
        end
        else if (pop && !push)
        begin
            count_next = count_reg - 2'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
            room_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            valid_reg <= (count_next != 2'h0);
            room_reg <= (count_next != 2'h2);
        end
    end

    // data path cleared too, so the link shows zero lanes after reset
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            head_reg <= '0;
            tail_reg <= '0;
        end
        else if (pop)
        begin
            if (count_reg == 2'h2)
            begin
                head_reg <= tail_reg;
                if (push)
                begin
                    tail_reg <= entry_in;
                end
            end
            else if (push)
            begin
                head_reg <= entry_in;
            end
        end
        else if (push)
        begin
            if (count_reg == 2'h0)
            begin
                head_reg <= entry_in;
            end
            else
            begin
                tail_reg <= entry_in;
            end
        end
    end

    assign sample_ready_o = room_reg;
    assign link.frame_valid = valid_reg;
    assign link.lane_data = head_reg[ENTRY_W-1:11];
    assign link.lane_active = head_reg[10:3];
    assign link.octet_count = head_reg[2:0];
endmodule : sample_mapper_tx

/* rtl/sample_mapper_rx.sv */
// receiver end: unpacks lane frames back into samples
`timescale 1ns/10ps
`include "sample_map_params.svh"
module sample_mapper_rx
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // configuration, must match the device end
    input wire logic [3:0] link_format_select_i,
    // link
    lane_link_if.rx link,
    // sample sink
    output logic sample_valid_o,
    input wire logic sample_ready_i,
    output sample_map_pkg::samples_t samples_o,
    output logic [7:0] lane_active_o
);
    import sample_map_pkg::*;

    function automatic logic [35:0] unpack3(input logic [39:0] x0,
        input logic [39:0] x1, input logic [39:0] x2);
        logic [15:0] l0;
        logic [15:0] l1;
        logic [15:0] l2;
        l0 = x0[39:24];
        l1 = x1[39:24];
        l2 = x2[39:24];
        return {l0[15:7], l0[3:0], l1[15:11], l1[7:0], l2[15],
            l2[11:3]};
    endfunction : unpack3

    samples_t s;
    logic [35:0] t_lo;
    logic [35:0] t_hi;
    lanes_t ln;

    assign ln = link.lane_data;

    always_comb
    begin
        s = '0;
        t_lo = unpack3(ln[0], ln[1], ln[2]);
        t_hi = unpack3(ln[3], ln[4], ln[5]);
        unique case (link_format_select_i)
            `FMT_1, `FMT_6:
            begin
                {s[0][0], s[0][1], s[1][0], s[1][1]} = t_lo;
                {s[2][0], s[2][1], s[3][0], s[3][1]} = t_hi;
            end
            `FMT_2, `FMT_7:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    s[c][0] = {ln[c][39:32], 1'b0};
                end
            end
            `FMT_3:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    s[c][0] = ln[c][39:31];
                    s[c][1] = ln[c][29:21];
                    s[c][2] = ln[c][19:11];
                    s[c][3] = ln[c][9:1];
                end
            end
            `FMT_4:
            begin
                {s[0][0], s[1][0], s[2][0], s[3][0]} = t_lo;
            end
            `FMT_5:
            begin
                s[0][0] = {ln[0][39:32], 1'b0};
                s[1][0] = {ln[0][31:24], 1'b0};
                s[2][0] = {ln[1][39:32], 1'b0};
                s[3][0] = {ln[1][31:24], 1'b0};
            end
            `FMT_8:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    s[c][0] = ln[c][39:31];
                    s[c][1] = ln[c][27:19];
                end
            end
            `FMT_9:
            begin
                for (int c = 0; c < 4; c++)
                begin
                    s[c][0] = {ln[2 * c][39:32], 1'b0};
                    s[c][1] = {ln[2 * c + 1][39:32], 1'b0};
                end
            end
            default:
            begin
                s = '0;
            end
        endcase
    end

    // one-deep hold; ready only when empty keeps ready a flop
    logic valid_reg;
    logic ready_reg;
    logic take;
    logic valid_next;

    assign take = link.frame_valid & ready_reg;
    assign valid_next = take | (valid_reg & ~sample_ready_i);

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            valid_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= valid_next;
            ready_reg <= ~valid_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            samples_o <= '0;
            lane_active_o <= 8'h00;
        end
        else if (take)
        begin
            samples_o <= s;
            lane_active_o <= link.lane_active;
        end
    end

    assign sample_valid_o = valid_reg;
    assign link.frame_ready = ready_reg;
endmodule : sample_mapper_rx

/* sim/sample_mapper_checker.sv */
// link checks between the two sample mapper ends
`timescale 1ns/10ps
module sample_mapper_checker
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // link signals
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire sample_map_pkg::lanes_t lane_data,
    input wire logic [7:0] lane_active,
    input wire logic [2:0] octet_count
);
    import sample_map_pkg::*;
    logic [39:0] tail_mask;
    logic tail_bad;
    logic idle_bad;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // bits past the last octet of a lane frame
    assign tail_mask = 40'hff_ffff_ffff >> (8 * octet_count);

    always_comb
    begin
        tail_bad = 1'b0;
        idle_bad = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            tail_bad = tail_bad | (|(lane_data[i] & tail_mask));
            idle_bad = idle_bad | (!lane_active[i] && (|lane_data[i]));
        end
    end

    property p_tail_zero;
        frame_valid |-> !tail_bad;
    endproperty
    a_tail_zero: assert property (p_tail_zero)
        else $error("bits past the frame not zero");

    property p_idle_lanes;
        frame_valid |-> !idle_bad;
    endproperty
    a_idle_lanes: assert property (p_idle_lanes)
        else $error("unused lane carries data");

    property p_lane_run;
        frame_valid |-> ((lane_active + 8'h1) & lane_active) == 8'h0;
    endproperty
    a_lane_run: assert property (p_lane_run)
        else $error("active lanes not a run from lane 0");

    property p_octets;
        frame_valid |-> (octet_count inside {3'h1, 3'h2, 3'h3, 3'h5})
            || (lane_active == 8'h0);
    endproperty
    a_octets: assert property (p_octets)
        else $error("octet count not a format value");

    property p_hold;
        frame_valid && !frame_ready |=> frame_valid && $stable(lane_data)
            && $stable(lane_active) && $stable(octet_count);
    endproperty
    a_hold: assert property (p_hold)
        else $error("frame changed before it was taken");

    property p_fmt3_pad;
        frame_valid && octet_count == 3'h5 |->
            {lane_data[0][30], lane_data[0][20], lane_data[0][10],
            lane_data[0][0]} == 4'h0;
    endproperty
    a_fmt3_pad: assert property (p_fmt3_pad)
        else $error("five octet frame pad bit set");

    property p_fmt8_pad;
        frame_valid && octet_count == 3'h3 |->
            {lane_data[0][30:28], lane_data[0][18:16]} == 6'h0;
    endproperty
    a_fmt8_pad: assert property (p_fmt8_pad)
        else $error("three octet frame pad bits set");

    property p_trio_pad;
        frame_valid && octet_count == 3'h2 && lane_active == 8'h07 |->
            {lane_data[0][30:28], lane_data[1][34:32], lane_data[2][38:36],
            lane_data[2][26:24]} == 12'h0;
    endproperty
    a_trio_pad: assert property (p_trio_pad)
        else $error("lane triple pad bits set");

    c_five_octets: cover property (frame_valid && octet_count == 3'h5);
    c_all_lanes: cover property (frame_valid && lane_active == 8'hff);
    c_stall: cover property (frame_valid && !frame_ready [*2]);
endmodule : sample_mapper_checker

/* sim/jesd_transport_sample_mapper_test.sv */
// self-checking bench for both mapper ends across the lane link
`timescale 1ns/10ps
module jesd_transport_sample_mapper_test;
    import sample_map_pkg::*;
    localparam logic [11:0] lane_tab [10] = '{12'h0, 12'h632, 12'h421,
        12'h421, 12'h321, 12'h211, 12'h632, 12'h421, 12'h421, 12'h842};
    localparam logic [2:0] oct_tab [10] = '{3'h0, 3'h2, 3'h1, 3'h5,
        3'h2, 3'h2, 3'h2, 3'h1, 3'h3, 3'h1};
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] fmt = 4'h1;
    mode_t mode = mode_quad;
    logic src_valid = 1'b0;
    logic src_ready;
    samples_t src_data = '0;
    logic sink_valid;
    logic sink_ready = 1'b1;
    samples_t sink_data;
    logic [7:0] sink_active;
    int err_total = 0;
    int num_checks = 0;

    lane_link_if link_bus ();
    sample_mapper_tx i_sample_mapper_tx (.clk_i(clk_i), .reset_i(reset_i),
        .link_format_select_i(fmt), .mode_i(mode),
        .sample_valid_i(src_valid), .sample_ready_o(src_ready),
        .samples_i(src_data), .link(link_bus.tx));
    sample_mapper_rx i_sample_mapper_rx (.clk_i(clk_i), .reset_i(reset_i),
        .link_format_select_i(fmt), .link(link_bus.rx),
        .sample_valid_o(sink_valid), .sample_ready_i(sink_ready),
        .samples_o(sink_data), .lane_active_o(sink_active));
    sample_mapper_checker i_sample_mapper_checker (.clk_i(clk_i),
        .reset_i(reset_i), .frame_valid(link_bus.frame_valid),
        .frame_ready(link_bus.frame_ready), .lane_data(link_bus.lane_data),
        .lane_active(link_bus.lane_active),
        .octet_count(link_bus.octet_count));

    always #25 clk_i = ~clk_i;

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [319:0] seen, input logic [319:0] want);
        num_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic cyc();
        @(posedge clk_i);
        #5;
    endtask : cyc

    task automatic wait_done(input int n);
        if (n >= 40)
        begin
            check(1'b1, 1'b0);
            end_sim();
        end
    endtask : wait_done

    function automatic samples_t pat(input int k);
        samples_t s;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 4; n++)
                s[c][n] = 9'((c * 4 + n) * 29 + k * 53 + 9'h10b);
        return s;
    endfunction : pat

    // expected frame built straight from the lane maps
    function automatic lanes_t exp_lanes(input logic [3:0] f, input int m,
        input samples_t s, output logic [7:0] act, output logic [2:0] oct);
        lanes_t l;
        logic [47:0] t0;
        logic [47:0] t1;
        int cnt;
        logic zs;
        logic zd;
        l = '0;
        zs = (m == 2);
        zd = (m == 1);
        t0 = {s[0][0], 3'h0, s[0][1], 3'h0, zs ? 8'h0 : s[1][0][8:1],
            s[1][0][0], 3'h0, s[1][1], 3'h0};
        t1 = {s[2][0], 3'h0, s[2][1], 3'h0, s[3][0], 3'h0, s[3][1], 3'h0};
        for (int c = 0; c < 4; c++)
        begin
            case (f)
                4'h1, 4'h6:
                begin
                    if (c < 3)
                    begin
                        l[c] = {t0[47 - 16 * c -: 16], 24'h0};
                        l[c + 3] = {t1[47 - 16 * c -: 16], 24'h0};
                    end
                end
                4'h2, 4'h7: l[c] = {s[c][0][8:1], 32'h0};
                4'h3: l[c] = {s[c][0], 1'b0, s[c][1], 1'b0, s[c][2], 1'b0,
                    s[c][3], 1'b0};
                4'h4:
                begin
                    l[0] = {s[0][0], 3'h0, zs ? 4'h0 : s[1][0][8:5], 24'h0};
                    l[1] = {s[1][0][4:0], 3'h0, zd ? 8'h0 : s[2][0][8:1],
                        24'h0};
                    l[2] = {s[2][0][0], 3'h0, s[3][0], 3'h0, 24'h0};
                end
                4'h5:
                begin
                    l[0] = {s[0][0][8:1], zs ? 8'h0 : s[1][0][8:1], 24'h0};
                    l[1] = {s[2][0][8:1], s[3][0][8:1], 24'h0};
                end
                4'h8: l[c] = {s[c][0], 3'h0, s[c][1], 3'h0, 16'h0};
                4'h9:
                begin
                    l[2 * c] = {s[c][0][8:1], 32'h0};
                    l[2 * c + 1] = {s[c][1][8:1], 32'h0};
                end
                default: ;
            endcase
        end
        cnt = int'((lane_tab[f] >> (8 - 4 * m)) & 12'hf);
        for (int i = 0; i < 8; i++)
            if (i >= cnt)
                l[i] = '0;
        act = 8'((9'h1 << cnt) - 9'h1);
        oct = oct_tab[f];
        return l;
    endfunction : exp_lanes

    // receiver view in quad mode: which samples survive the trip
    function automatic samples_t exp_rx(input logic [3:0] f,
        input samples_t s);
        samples_t r;
        logic keep;
        r = '0;
        for (int c = 0; c < 4; c++)
            for (int n = 0; n < 4; n++)
            begin
                keep = (f == 4'h3) || (n < 2 && f inside {4'h1, 4'h6,
                    4'h8, 4'h9}) || (n == 0 && f inside {4'h2, 4'h4,
                    4'h5, 4'h7});
                if (keep)
                    r[c][n] = s[c][n];
                // 8-bit formats carry only bits 8:1
                if (f inside {4'h2, 4'h5, 4'h7, 4'h9})
                    r[c][n][0] = 1'b0;
            end
        return r;
    endfunction : exp_rx

    // valid left high: callers drop it, so back to back pushes stay legal
    task automatic push(input samples_t s);
        int n;
        src_data = s;
        src_valid = 1'b1;
        for (n = 0; n < 40 && src_ready !== 1'b1; n++)
            cyc();
        wait_done(n);
        cyc();
    endtask : push

    task automatic run_frame(input logic [3:0] f, input int m, input int k);
        samples_t s;
        lanes_t l;
        logic [7:0] act;
        logic [2:0] oct;
        int n;
        s = pat(k);
        l = exp_lanes(f, m, s, act, oct);
        fmt = f;
        mode = mode_t'(m);
        push(s);
        src_valid = 1'b0;
        for (n = 0; n < 40 && link_bus.frame_valid !== 1'b1; n++)
            cyc();
        wait_done(n);
        check(link_bus.lane_data, l);
        check(link_bus.lane_active, act);
        check(link_bus.octet_count, oct);
        for (n = 0; n < 40 && sink_valid !== 1'b1; n++)
            cyc();
        wait_done(n);
        check(sink_active, act);
        if (m == 0)
            check(sink_data, exp_rx(f, s));
        cyc();
    endtask : run_frame

    // receiver stalls until both buffer slots and the receiver are full
    task automatic stall_run();
        int k;
        int n;
        fmt = 4'h3;
        mode = mode_quad;
        sink_ready = 1'b0;
        for (k = 0; k < 8 && src_ready === 1'b1; k++)
            push(pat(20 + k));
        check(k, 3);
        src_data = pat(40);
        for (n = 0; n < 3; n++)
        begin
            cyc();
            check(src_ready, 1'b0);
        end
        src_valid = 1'b0;
        sink_ready = 1'b1;
        for (k = 0; k < 3; k++)
        begin
            for (n = 0; n < 40 && sink_valid !== 1'b1; n++)
                cyc();
            wait_done(n);
            check(sink_data, pat(20 + k));
            cyc();
        end
        cyc();
        check({src_ready, link_bus.frame_valid, sink_valid}, 3'h4);
    endtask : stall_run

    // reset in mid-run with a frame standing on the link
    task automatic reset_run();
        sink_ready = 1'b0;
        push(pat(60));
        src_valid = 1'b0;
        reset_i = 1'b1;
        cyc();
        cyc();
        check({link_bus.frame_valid, link_bus.lane_active, sink_valid},
            0);
        reset_i = 1'b0;
        sink_ready = 1'b1;
    endtask : reset_run

    initial
    begin
        repeat (20) cyc();
        check({src_ready, link_bus.frame_valid, sink_valid}, 3'h0);
        reset_i = 1'b0;
        for (int f = 0; f < 10; f++)
            for (int m = 0; m < 3; m++)
                run_frame(4'(f), m, f * 3 + m);
        stall_run();
        reset_run();
        run_frame(4'h9, 0, 61);
        end_sim();
    end
endmodule : jesd_transport_sample_mapper_test
